// >>> rngs_pkg.sv
// Constants and types shared by the remote network grant scheduler files
package rngs_pkg;
	// Clock and internal tick timing
	localparam int CLK_NS = 100;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int TICK_W = 16;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] GRANT_OFS = 8'h04;
	localparam logic [7:0] REPLY_OFS = 8'h08;
	localparam logic [7:0] IVL_OFS = 8'h0c;
	localparam logic [7:0] DROP_OFS = 8'h10;
	localparam logic [7:0] STAT_OFS = 8'h14;

	// Control field positions
	localparam int CTRL_EN_POS = 0;
	localparam int CTRL_SLAVE_POS = 1;

	// Status field positions
	localparam int STAT_DROP_POS = 0;
	localparam int STAT_SWEEP_POS = 7;
	localparam int STAT_STEP_POS = 8;
	localparam int STAT_PEND_POS = 9;
	localparam int STAT_RTS_POS = 10;
	localparam int STAT_CTS_POS = 11;
	localparam int STAT_ST_POS = 12;
	localparam int STAT_KIND_POS = 16;
	localparam int STAT_LVL_POS = 24;

	// Values after reset
	localparam logic [15:0] REPLY_RST = 16'h07d0;
	localparam logic [15:0] IVL_RST = 16'h0064;
	localparam logic [6:0] DROP_RST = 7'h00;

	// Drop numbering and grant address coding
	localparam int DROP_W = 7;
	localparam logic [7:0] MAX_DROP = 8'h63;
	localparam logic [7:0] SWEEP_BASE = 8'h64;
	localparam logic [7:0] SWEEP_TOP = 8'hc7;

	// Retries after the first try of a forwarded message
	localparam logic [1:0] RETRY_MAX = 2'h2;

	// Buffer shape
	localparam int FIFO_WIDTH = 32;
	localparam int FIFO_DEPTH = 32;

	typedef enum logic [2:0] {ST_IDLE, ST_KEY, ST_SEND, ST_WAIT, ST_GAP} rngs_state_type;
	typedef enum logic [1:0] {K_NORMAL, K_GRANT, K_SLAVE} rngs_kind_type;
endpackage

// >>> rngs_fifo.sv
// Synchronous FIFO with valid and ready on both sides
module rngs_fifo
	import rngs_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr;
		logic [AW:0] rd;
	} rngs_fifo_state_type;

	rngs_fifo_state_type r_q;
	rngs_fifo_state_type r_d;

	// Pointers carry one extra bit so full and empty differ
	assign level = r_q.wr - r_q.rd;
	assign in_ready = (level != (AW + 1)'(DEPTH));
	assign out_valid = (r_q.wr != r_q.rd);
	assign out_data = r_q.mem[r_q.rd[AW-1:0]];

	// Push and pop may happen in the same cycle
	always_comb begin
		r_d = r_q;
		if (in_valid && in_ready) begin
			r_d.mem[r_q.wr[AW-1:0]] = in_data;
			r_d.wr = r_q.wr + (AW + 1)'(1);
		end
		if (out_valid && out_ready) begin
			r_d.rd = r_q.rd + (AW + 1)'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end
endmodule

// >>> rngs_scheduler.sv
// Remote network link grant scheduler, master and slave roles, APB registers
// Operation
// RULE1: Only one transaction on the link at a time; next starts after completion/timeout.
// RULE2: Master buffers local messages arriving mid-transaction, sends them once it finishes.
// RULE3: Slave keeps upstream messages buffered until it receives a grant.
// RULE4: Granted slave with messages sends the oldest one, acting as originator.
// RULE5: Slave sends at most one message per grant received.
// RULE6: Empty slave ignores a grant; master ends the grant on reply timeout.
// RULE7: Slave answers every grant while buffered, with no lockout period.
// RULE8: Slave must begin its response within the configured reply timeout.
// RULE9: Software writes a slave drop number to request one grant.
// RULE10: Software writes 100 to grant slave zero.
// RULE11: Writing 100 plus n sweeps grants from n down to zero, then stops.
// RULE12: A sweep grants every drop, present or not.
// RULE13: Each step: grant, reply timeout, grant interval, then end or decrement.
// RULE14: Queued master messages are sent inside the interval after the grant.
// RULE15: Local messages pause the sweep after the current grant; it resumes afterwards.
// RULE16: One master serves up to 99 slave drops.
// RULE17: Transmitter keyed by request and clear to send; port 0 lacks this mode.
// RULE18: After the granted slave's transaction, the master resumes sequencing.
// RULE19: Reply timeout and grant interval are tick-driven down-counters expiring at zero.
module rngs_scheduler
	import rngs_pkg::*;
#(
	parameter int PORT_INDEX = 1,
	parameter int TICK_COUNT = TICK_CYCLES,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic loc_valid,
	output logic loc_ready,
	input wire logic [FIFO_WIDTH-1:0] loc_data,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [FIFO_WIDTH-1:0] tx_data,
	output logic tx_grant,
	output logic [DROP_W-1:0] tx_drop,
	input wire logic rx_grant,
	input wire logic [DROP_W-1:0] rx_drop,
	input wire logic rx_done,
	output logic rts,
	input wire logic cts
);
	localparam int LW = $clog2(DEPTH) + 1;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_COUNT - 1);
	// Port 0 has no handshake lines, so the protocol stays off there
	localparam logic PORT_OK = (PORT_INDEX != 0); // RULE17

	typedef struct packed {
		rngs_state_type st;
		rngs_kind_type kind;
		logic enable;
		logic slave_role;
		logic [DROP_W-1:0] own_drop;
		logic [15:0] reply_cfg;
		logic [15:0] ivl_cfg;
		logic [7:0] grant_wr;
		logic grant_pend;
		logic [DROP_W-1:0] pend_drop;
		logic pend_sweep;
		logic [DROP_W-1:0] drop;
		logic sweep;
		logic step;
		logic [15:0] reply_cnt;
		logic [15:0] ivl_cnt;
		logic [TICK_W-1:0] tick_cnt;
		logic [1:0] retry;
		logic [FIFO_WIDTH-1:0] msg;
		logic rts;
		logic [2:0] cts_sync;
		logic cts_f;
		logic [31:0] prdata;
		logic pslverr;
	} rngs_regs_type;

	rngs_regs_type r_q;
	rngs_regs_type r_d;

	logic fifo_valid;
	logic fifo_pop;
	logic [FIFO_WIDTH-1:0] fifo_data;
	logic [LW-1:0] fifo_level;
	logic tick;
	logic active;
	logic setup;
	logic wr_acc;
	logic [7:0] gval;

	// Upstream or forwarded messages wait here, oldest first
	rngs_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(loc_valid),
		.in_ready(loc_ready),
		.in_data(loc_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data),
		.level(fifo_level)
	);

	// Zero wait state slave; answer registered during setup
	assign pready = 1'b1;
	assign prdata = r_q.prdata;
	assign pslverr = r_q.pslverr;

	// Link side outputs
	assign tx_valid = (r_q.st == ST_SEND);
	assign tx_data = r_q.msg;
	assign tx_grant = (r_q.kind == K_GRANT);
	assign tx_drop = r_q.drop;
	assign rts = r_q.rts;

	assign active = r_q.enable && PORT_OK; // RULE17
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	assign gval = pwdata[7:0];
	assign tick = (r_q.tick_cnt == TICK_LAST);

	always_comb begin
		r_d = r_q;
		fifo_pop = 1'b0;

		// Free running tick divider
		r_d.tick_cnt = tick ? '0 : r_q.tick_cnt + TICK_W'(1);

		// Clear to send crosses in; accept a change once stages two and three agree
		r_d.cts_sync = {r_q.cts_sync[1:0], cts};
		if (r_q.cts_sync[1] == r_q.cts_sync[2]) begin
			r_d.cts_f = r_q.cts_sync[2];
		end

		// Timers count down on the tick and rest at zero
		if (tick && r_q.reply_cnt != 16'h0000) begin
			r_d.reply_cnt = r_q.reply_cnt - 16'h0001; // RULE19
		end
		if (tick && r_q.ivl_cnt != 16'h0000 && r_q.st == ST_GAP) begin
			r_d.ivl_cnt = r_q.ivl_cnt - 16'h0001; // RULE19
		end

		// Sequencer: a single state machine keeps the link single threaded
		if (!active) begin
			r_d.st = ST_IDLE;
			r_d.rts = 1'b0;
			r_d.step = 1'b0;
			r_d.sweep = 1'b0;
		end else begin
			case (r_q.st)
				ST_IDLE: begin
					r_d.rts = 1'b0;
					if (r_q.slave_role) begin
						// Grants to other drops and grants with nothing queued are ignored
						if (rx_grant && rx_drop == r_q.own_drop && fifo_valid) begin // RULE3 RULE6 RULE7
							r_d.kind = K_SLAVE; // RULE4
							r_d.reply_cnt = r_q.reply_cfg; // RULE8
							r_d.st = ST_KEY;
						end
					end else if (fifo_valid) begin
						r_d.kind = K_NORMAL; // RULE2
						r_d.retry = 2'h0;
						r_d.st = ST_KEY;
					end else if (r_q.grant_pend) begin
						r_d.grant_pend = 1'b0;
						r_d.drop = r_q.pend_drop;
						r_d.sweep = r_q.pend_sweep;
						r_d.kind = K_GRANT;
						r_d.st = ST_KEY;
					end
				end
				ST_KEY: begin
					r_d.rts = 1'b1; // RULE17
					if (r_q.cts_f) begin
						r_d.st = ST_SEND;
						if (r_q.kind == K_GRANT) begin
							r_d.msg = FIFO_WIDTH'(r_q.drop);
						end else if (r_q.kind == K_SLAVE || r_q.retry == 2'h0) begin
							// At most one message leaves the buffer per grant
							r_d.msg = fifo_data; // RULE4 RULE5
							fifo_pop = 1'b1;
						end
					end else if (r_q.kind == K_SLAVE && r_q.reply_cnt == 16'h0000) begin
						// Too late to answer; message stays queued for a later grant
						r_d.rts = 1'b0; // RULE8
						r_d.st = ST_IDLE;
					end
				end
				ST_SEND: begin
					if (tx_ready) begin
						r_d.rts = 1'b0;
						r_d.reply_cnt = r_q.reply_cfg;
						r_d.st = ST_WAIT;
					end
				end
				ST_WAIT: begin
					// Nothing else starts until a reply or the timeout
					if (rx_done || r_q.reply_cnt == 16'h0000) begin // RULE1 RULE6
						case (r_q.kind)
							K_NORMAL: begin
								if (!rx_done && r_q.retry != RETRY_MAX) begin
									r_d.retry = r_q.retry + 2'h1;
									r_d.st = ST_KEY;
								end else begin
									r_d.st = r_q.step ? ST_GAP : ST_IDLE; // RULE15
								end
							end
							K_GRANT: begin
								r_d.ivl_cnt = r_q.ivl_cfg; // RULE13
								r_d.step = 1'b1;
								r_d.st = ST_GAP; // RULE18
							end
							default: begin
								r_d.st = ST_IDLE; // RULE18
							end
						endcase
					end
				end
				ST_GAP: begin
					if (fifo_valid) begin
						// Sweep pauses while queued messages go out
						r_d.kind = K_NORMAL; // RULE14 RULE15
						r_d.retry = 2'h0;
						r_d.st = ST_KEY;
					end else if (r_q.ivl_cnt == 16'h0000) begin
						r_d.step = 1'b0;
						if (r_q.sweep && r_q.drop != '0) begin
							// No presence check: every drop in range is granted
							r_d.drop = r_q.drop - DROP_W'(1); // RULE12 RULE13
							r_d.kind = K_GRANT;
							r_d.st = ST_KEY;
						end else begin
							r_d.sweep = 1'b0; // RULE11 RULE13
							r_d.st = ST_IDLE;
						end
					end
				end
				default: begin
					r_d.st = ST_IDLE;
				end
			endcase
		end

		// Register reads are captured in the setup cycle
		if (setup) begin
			r_d.pslverr = 1'b0;
			r_d.prdata = 32'h0000_0000;
			case (paddr)
				CTRL_OFS: begin
					r_d.prdata[CTRL_EN_POS] = r_q.enable;
					r_d.prdata[CTRL_SLAVE_POS] = r_q.slave_role;
				end
				GRANT_OFS: r_d.prdata[7:0] = r_q.grant_wr;
				REPLY_OFS: r_d.prdata[15:0] = r_q.reply_cfg;
				IVL_OFS: r_d.prdata[15:0] = r_q.ivl_cfg;
				DROP_OFS: r_d.prdata[DROP_W-1:0] = r_q.own_drop;
				STAT_OFS: begin
					r_d.prdata[STAT_DROP_POS +: DROP_W] = r_q.drop;
					r_d.prdata[STAT_SWEEP_POS] = r_q.sweep;
					r_d.prdata[STAT_STEP_POS] = r_q.step;
					r_d.prdata[STAT_PEND_POS] = r_q.grant_pend;
					r_d.prdata[STAT_RTS_POS] = r_q.rts;
					r_d.prdata[STAT_CTS_POS] = r_q.cts_f;
					r_d.prdata[STAT_ST_POS +: 3] = r_q.st;
					r_d.prdata[STAT_KIND_POS +: 2] = r_q.kind;
					r_d.prdata[STAT_LVL_POS +: LW] = fifo_level;
				end
				default: r_d.pslverr = 1'b1;
			endcase
		end

		// Writes land in the access cycle; they come after the sequencer so a set wins
		if (wr_acc) begin
			case (paddr)
				CTRL_OFS: begin
					r_d.enable = pwdata[CTRL_EN_POS];
					r_d.slave_role = pwdata[CTRL_SLAVE_POS];
				end
				GRANT_OFS: begin
					r_d.grant_wr = gval;
					if (gval != 8'h00 && gval <= MAX_DROP) begin
						r_d.grant_pend = 1'b1; // RULE9 RULE16
						r_d.pend_drop = DROP_W'(gval);
						r_d.pend_sweep = 1'b0;
					end else if (gval == SWEEP_BASE) begin
						r_d.grant_pend = 1'b1; // RULE10
						r_d.pend_drop = '0;
						r_d.pend_sweep = 1'b0;
					end else if (gval > SWEEP_BASE && gval <= SWEEP_TOP) begin
						r_d.grant_pend = 1'b1; // RULE11 RULE16
						r_d.pend_drop = DROP_W'(gval - SWEEP_BASE);
						r_d.pend_sweep = 1'b1;
					end
				end
				REPLY_OFS: r_d.reply_cfg = pwdata[15:0];
				IVL_OFS: r_d.ivl_cfg = pwdata[15:0];
				DROP_OFS: r_d.own_drop = pwdata[DROP_W-1:0];
				default: ;
			endcase
		end
	end

	// Every field gets a constant on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q <= '0;
			r_q.st <= ST_IDLE;
			r_q.kind <= K_NORMAL;
			r_q.reply_cfg <= REPLY_RST;
			r_q.ivl_cfg <= IVL_RST;
			r_q.own_drop <= DROP_RST;
		end else begin
			r_q <= r_d;
		end
	end
endmodule

// >>> rngs_scheduler_asserts.sv
// Port checks for the grant scheduler
module rngs_sched_chk
	import rngs_pkg::*;
#(
	parameter int PORT_INDEX = 1,
	parameter int TICK_COUNT = 4,
	parameter int DEPTH = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic loc_valid,
	input wire logic loc_ready,
	input wire logic [FIFO_WIDTH-1:0] loc_data,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [FIFO_WIDTH-1:0] tx_data,
	input wire logic tx_grant,
	input wire logic [DROP_W-1:0] tx_drop,
	input wire logic rx_grant,
	input wire logic [DROP_W-1:0] rx_drop,
	input wire logic rx_done,
	input wire logic rts,
	input wire logic cts
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Link side: keyed, one word, held until taken
	a_send_keyed: assert property (tx_valid |-> rts)
		else $error("offer without key");
	a_cts_first: assert property ($rose(tx_valid) |-> $past(cts, 2))
		else $error("offer before clear");
	a_offer_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("offer dropped");
	a_one_word: assert property (tx_valid && tx_ready |=> !tx_valid [*3])
		else $error("next word too soon");
	a_key_freed: assert property (tx_valid && tx_ready |=> !rts)
		else $error("key held");
	a_drop_range: assert property (tx_valid && tx_grant |-> tx_drop <= 7'h63)
		else $error("drop too high");
	a_grant_word: assert property (tx_valid && tx_grant |-> tx_data == {25'h0, tx_drop})
		else $error("grant word");
	// Register bus never stalls; holes answer with an error
	a_apb_ready: assert property (psel && penable |-> pready)
		else $error("wait state");
	a_bad_addr: assert property (psel && !penable && paddr > 8'h14 |=> pslverr)
		else $error("hole accepted");
	c_grant: cover property (tx_valid && tx_ready && tx_grant);
	c_msg: cover property (tx_valid && tx_ready && !tx_grant);
	c_full: cover property (!loc_ready);
endmodule

bind rngs_scheduler rngs_sched_chk #(.PORT_INDEX(PORT_INDEX), .TICK_COUNT(TICK_COUNT),
	.DEPTH(DEPTH)) rngs_sched_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .loc_valid(loc_valid), .loc_ready(loc_ready),
	.loc_data(loc_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
	.tx_grant(tx_grant), .tx_drop(tx_drop), .rx_grant(rx_grant), .rx_drop(rx_drop),
	.rx_done(rx_done), .rts(rts), .cts(cts));

// >>> rngs_remote.sv
// Far-side station: clear to send, accept, answer
module rngs_remote (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic rts,
	input wire logic tx_valid,
	input wire logic answer,
	input wire logic slow,
	output logic cts,
	output logic tx_ready,
	output logic rx_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] key_q;
	logic [1:0] wait_q;
	logic [2:0] done_q;
	// Modem warm-up of two edges; silent when told not to answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_q <= 2'h0;
			wait_q <= 2'h0;
			done_q <= 3'h0;
			rx_done <= 1'b0;
		end else begin
			key_q <= {key_q[0], rts};
			wait_q <= (tx_valid && !tx_ready) ? wait_q + 2'h1 : 2'h0;
			rx_done <= (done_q == 3'h1);
			if (tx_valid && tx_ready && answer) begin
				done_q <= 3'h4;
			end else if (done_q != 3'h0) begin
				done_q <= done_q - 3'h1;
			end
		end
	end
	// Clear drops at once when the key is released
	assign cts = key_q[1] && rts;
	assign tx_ready = tx_valid && (!slow || wait_q == 2'h3);
endmodule

// >>> rngs_scheduler_tb.sv
// Self-checking bench for the grant scheduler
module rngs_scheduler_tb
	import rngs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} rngs_row_type;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic loc_valid = 0, rx_grant = 0, answer = 0, slow = 0;
	logic pready, pslverr, loc_ready, tx_valid, tx_ready, tx_grant, rts, cts, rx_done;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, loc_data = 32'h0, prdata, tx_data, rd;
	logic [6:0] tx_drop, rx_drop = 7'h0;
	logic rts_p0, tx_valid_p0, p0_keyed = 0;
	logic [32:0] sent[$];
	int errors = 0, checked = 0, cycles = 0, pushed = 0;
	logic [7:0] ra[4] = '{CTRL_OFS, REPLY_OFS, IVL_OFS, DROP_OFS};
	logic [31:0] rv[4] = '{32'h0, {16'h0, REPLY_RST}, {16'h0, IVL_RST}, {25'h0, DROP_RST}};
	rngs_row_type rows[5] = '{'{CTRL_OFS, 32'h1, 32'h1, 1'b0}, '{REPLY_OFS, 32'h6, 32'h6, 1'b0},
		'{IVL_OFS, 32'h3, 32'h3, 1'b0}, '{DROP_OFS, 32'h9, 32'h9, 1'b0},
		'{8'h18, 32'h1, 32'h0, 1'b1}};

	rngs_scheduler #(.TICK_COUNT(4)) rngs_scheduler_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .loc_valid(loc_valid),
		.loc_ready(loc_ready), .loc_data(loc_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data), .tx_grant(tx_grant), .tx_drop(tx_drop), .rx_grant(rx_grant),
		.rx_drop(rx_drop), .rx_done(rx_done), .rts(rts), .cts(cts));
	// Port zero lacks handshake lines; it sees all traffic but must never key up
	rngs_scheduler #(.PORT_INDEX(0), .TICK_COUNT(4)) rngs_scheduler_p0_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(), .pready(), .pslverr(), .loc_valid(loc_valid), .loc_ready(),
		.loc_data(loc_data), .tx_valid(tx_valid_p0), .tx_ready(1'b1), .tx_data(), .tx_grant(),
		.tx_drop(), .rx_grant(rx_grant), .rx_drop(rx_drop), .rx_done(rx_done), .rts(rts_p0),
		.cts(1'b1));
	rngs_remote rngs_remote_inst (.pclk(pclk), .presetn(presetn), .rts(rts), .cts(cts),
		.tx_valid(tx_valid), .answer(answer), .slow(slow), .tx_ready(tx_ready),
		.rx_done(rx_done));

	always #50 pclk = ~pclk;
	// Log accepted link words and buffer intake; cut a hang short
	always @(posedge pclk) begin
		cycles++;
		if (tx_valid && tx_ready)
			sent.push_back({tx_grant, tx_data});
		if (loc_valid && loc_ready)
			pushed++;
		if (rts_p0 || tx_valid_p0)
			p0_keyed = 1'b1;
		if (cycles == 30000) begin
			errors++;
			wrap_up();
		end
	end

	task wrap_up();
		if (errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [32:0] got, input logic [32:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task take(input logic [32:0] exp);
		chk((sent.size() != 0) ? sent.pop_front() : 33'hx, exp);
	endtask
	// Setup then access; hold until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// Poll until idle, nothing pending, no sweep and buffer empty
	task wait_idle();
		int n;
		n = 0;
		do begin
			apb(0, STAT_OFS, 32'h0);
			n++;
		end while ((rd & 32'h3f00_7280) !== 32'h0 && n < 3000);
		chk(33'(n < 3000), 33'h1);
	endtask
	task push(input int n, input logic [31:0] base);
		for (int i = 0; i < n; i++) begin
			loc_valid <= 1;
			loc_data <= base + 32'(i);
			@(posedge pclk);
		end
		loc_valid <= 0;
		@(posedge pclk);
	endtask
	task bid(input logic [6:0] d);
		rx_drop <= d;
		rx_grant <= 1;
		@(posedge pclk);
		rx_grant <= 0;
		repeat (80) @(posedge pclk);
	endtask
	task run_rows();
		foreach (rows[i]) begin
			apb(1, rows[i].a, rows[i].w);
			apb(0, rows[i].a, 32'h0);
			chk({er, rd}, {rows[i].e, rows[i].r});
		end
	endtask
	// Grants count down from g-1 to zero, messages in order between them
	task mixed(input int g, input int m);
		logic [32:0] e;
		int k;
		k = 0;
		repeat (g + m) begin
			e = (sent.size() != 0) ? sent.pop_front() : 33'hx;
			if (e[32] === 1'b1) begin
				g--;
				chk(e, {1'b1, 32'(g)});
			end else begin
				chk(e, {1'b0, 32'ha5a5_0000 + 32'(k)});
				k++;
			end
		end
		chk(33'(k), 33'(m));
	endtask

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		run_rows();
		// Reset in mid-run restores defaults
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		foreach (ra[i]) begin
			apb(0, ra[i], 32'h0);
			chk({er, rd}, {1'b0, rv[i]});
		end
		run_rows();
		// Single grants and a three-drop sweep to a silent far side end on timeout
		apb(1, GRANT_OFS, 32'h5);
		wait_idle();
		take({1'b1, 32'h5});
		apb(1, GRANT_OFS, 32'h64);
		wait_idle();
		take({1'b1, 32'h0});
		apb(1, GRANT_OFS, 32'h66);
		wait_idle();
		for (int d = 2; d >= 0; d--)
			take({1'b1, 32'(d)});
		// Codes past the sweep range and plain zero start nothing
		apb(1, GRANT_OFS, 32'hc8);
		apb(1, GRANT_OFS, 32'h0);
		wait_idle();
		chk(33'(sent.size()), 33'h0);
		// Unanswered message: first try and two retries
		push(1, 32'h1234_5678);
		wait_idle();
		repeat (3) take({1'b0, 32'h1234_5678});
		// Local words during a sweep slip in between grants
		answer <= 1;
		apb(1, GRANT_OFS, 32'h67);
		push(2, 32'ha5a5_0000);
		wait_idle();
		mixed(4, 2);
		// Link off: buffer fills and refuses, then drains against a slow far side
		apb(1, CTRL_OFS, 32'h0);
		slow <= 1;
		pushed = 0;
		push(34, 32'h0);
		chk(33'(pushed), 33'(FIFO_DEPTH));
		apb(1, CTRL_OFS, 32'h1);
		wait_idle();
		for (int i = 0; i < FIFO_DEPTH; i++)
			take({1'b0, 32'(i)});
		// Slave role: held until its own grant, one word per grant
		apb(1, CTRL_OFS, 32'h3);
		slow <= 0;
		push(2, 32'hbeef_0000);
		bid(7'h8);
		chk(33'(sent.size()), 33'h0);
		bid(7'h9);
		take({1'b0, 32'hbeef_0000});
		chk(33'(sent.size()), 33'h0);
		// Reply window already spent: the slave stays silent and keeps its word
		apb(1, REPLY_OFS, 32'h0);
		bid(7'h9);
		chk(33'(sent.size()), 33'h0);
		apb(1, REPLY_OFS, 32'h6);
		bid(7'h9);
		take({1'b0, 32'hbeef_0001});
		chk(33'(p0_keyed), 33'h0);
		wrap_up();
	end
endmodule
